// *** hdl/hpp_pkg.sv ***
// Purpose: shared constants and types for the host parallel bus port
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: pin-level configuration values are named here once
package hpp_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int HPP_AW = 14;
	localparam int HPP_DW = 16;
	localparam int HPP_BW = 8;
	// ----------------------------------------------------------------
	// configuration pin meanings
	// ----------------------------------------------------------------
	localparam logic HPP_STYLE_SEPARATE = 1'b1;
	localparam logic HPP_WIDTH_16 = 1'b1;
	localparam logic HPP_ORDER_HI_FIRST = 1'b1;
	localparam logic HPP_LANE_FIRST = 1'b0;
	localparam logic HPP_DIR_READ = 1'b1;
	localparam logic [7:0] HPP_BYTE_ZERO = 8'h00;
	// ----------------------------------------------------------------
	// internal storage sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HPP_IDLE,
		HPP_FETCH,
		HPP_PREF,
		HPP_WRITE
	} hpp_state_e;
endpackage

// *** hdl/hpp_port.sv ***
// Purpose: host parallel bus port with read stall and read-ahead
// Assumes: host pins already synchronous to clk; storage answers by ack
// Notes: one read-ahead word; a write breaks the chain unless it starts during a read fetch or as a read-ahead launches
`timescale 1ns/1ns
module hpp_port
	import hpp_pkg::*;
#(
	parameter int AW = HPP_AW
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic strobe_style_select,
	input wire logic stall_polarity_select,
	input wire logic host_width_select,
	input wire logic byte_order_select,
	input wire logic chip_sel_n,
	input wire logic dir_or_write_n,
	input wire logic common_access_pulse_n,
	input wire logic [AW-1:0] host_word_addr,
	input wire logic byte_lane_addr,
	input wire logic [HPP_DW-1:0] host_data_bus_i,
	output logic [HPP_DW-1:0] host_data_bus_o,
	output logic host_data_oe_lo,
	output logic host_data_oe_hi,
	output logic host_stall,
	output logic mem_req,
	output logic mem_we,
	output logic [AW-1:0] mem_addr,
	output logic [HPP_DW-1:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [HPP_DW-1:0] mem_rdata
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		hpp_state_e state;
		logic rd_prev;
		logic wr_prev;
		logic cur_valid;
		logic [AW-1:0] cur_addr;
		logic [HPP_DW-1:0] cur_word;
		logic pf_valid;
		logic [AW-1:0] pf_addr;
		logic [HPP_DW-1:0] pf_word;
		logic pf_req;
		logic pf_drop;
		logic rd_pend;
		logic [AW-1:0] rd_addr;
		logic wr_pend;
		logic [AW-1:0] wr_addr;
		logic [HPP_DW-1:0] wr_word;
		logic [AW-1:0] hold_addr;
		logic hold_lane;
		logic [HPP_DW-1:0] hold_data;
		logic [AW-1:0] op_addr;
		logic [HPP_DW-1:0] op_wdata;
		logic [HPP_DW-1:0] dout;
	} hpp_regs_s;

	hpp_regs_s s_q;
	hpp_regs_s s_d;
	logic wide;
	logic lane;
	logic rd_act;
	logic wr_act;
	logic rd_start;
	logic pf_hit;
	logic reuse;
	logic cur_ok;
	logic stall_on;
	logic sel_hi;
	logic hsel_hi;
	logic [HPP_DW-1:0] serve_word;

	// ----------------------------------------------------------------
	// strobe decode
	// ----------------------------------------------------------------
	assign wide = host_width_select == HPP_WIDTH_16;
	assign lane = wide ? HPP_LANE_FIRST : byte_lane_addr;
	// separate style: second pin is read enable, first is write strobe
	// common style: second pin strobes, first gives the direction
	assign rd_act = !chip_sel_n &&
		((strobe_style_select == HPP_STYLE_SEPARATE) ?
		!common_access_pulse_n :
		(!common_access_pulse_n && dir_or_write_n == HPP_DIR_READ));
	assign wr_act = !chip_sel_n &&
		((strobe_style_select == HPP_STYLE_SEPARATE) ?
		!dir_or_write_n :
		(!common_access_pulse_n && dir_or_write_n != HPP_DIR_READ));
	assign rd_start = rd_act && !s_q.rd_prev;
	assign pf_hit = s_q.pf_valid && s_q.pf_addr == host_word_addr;
	assign cur_ok = s_q.cur_valid && s_q.cur_addr == host_word_addr;
	// second byte of a word comes from the word already held
	assign reuse = !wide && lane != HPP_LANE_FIRST && cur_ok;
	// stall is combinational so a hit never shows even one stall cycle
	assign stall_on = rd_act &&
		!(rd_start ? (pf_hit || reuse) : cur_ok);
	assign host_stall = ~(stall_on ^ stall_polarity_select);
	assign sel_hi = lane ^ (byte_order_select == HPP_ORDER_HI_FIRST);
	assign hsel_hi = s_q.hold_lane ^
		(byte_order_select == HPP_ORDER_HI_FIRST);
	assign serve_word = (s_q.state == HPP_FETCH && mem_ack) ? mem_rdata :
		(rd_start && pf_hit) ? s_q.pf_word : s_q.cur_word;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rd_prev = rd_act;
		s_d.wr_prev = wr_act;
		// storage sequencer first; host events below override it
		case (s_q.state)
			HPP_IDLE: begin
				if (s_q.wr_pend) begin
					s_d.state = HPP_WRITE;
					s_d.op_addr = s_q.wr_addr;
					s_d.op_wdata = s_q.wr_word;
					s_d.wr_pend = 1'b0;
				end else if (s_q.rd_pend) begin
					s_d.state = HPP_FETCH;
					s_d.op_addr = s_q.rd_addr;
					s_d.rd_pend = 1'b0;
				end else if (s_q.pf_req) begin
					s_d.state = HPP_PREF;
					s_d.op_addr = s_q.cur_addr + AW'(1);
					s_d.pf_req = 1'b0;
					s_d.pf_drop = 1'b0;
				end
			end
			HPP_FETCH: begin
				if (mem_ack) begin
					s_d.cur_word = mem_rdata;
					s_d.cur_addr = s_q.op_addr;
					s_d.cur_valid = 1'b1;
					s_d.pf_req = 1'b1;
					s_d.state = HPP_IDLE;
				end
			end
			HPP_PREF: begin
				if (mem_ack) begin
					// kept even if never read; dropped if a write hit mid-way
					s_d.pf_word = mem_rdata;
					s_d.pf_addr = s_q.op_addr;
					s_d.pf_valid = !s_q.pf_drop;
					s_d.state = HPP_IDLE;
				end
			end
			HPP_WRITE: begin
				if (mem_ack) begin
					s_d.state = HPP_IDLE;
				end
			end
			default: begin
				s_d.state = HPP_IDLE;
			end
		endcase
		// read start: promote the read-ahead word or begin a new read
		if (rd_start && !reuse) begin
			if (pf_hit) begin
				s_d.cur_word = s_q.pf_word;
				s_d.cur_addr = s_q.pf_addr;
				s_d.cur_valid = 1'b1;
				s_d.pf_valid = 1'b0;
				s_d.pf_req = 1'b1;
			end else begin
				s_d.cur_valid = 1'b0;
				s_d.pf_valid = 1'b0;
				s_d.pf_req = 1'b0;
				s_d.rd_pend = 1'b1;
				s_d.rd_addr = host_word_addr;
				if (s_q.state == HPP_PREF) begin
					s_d.pf_drop = 1'b1;
				end
			end
		end
		if (rd_act) begin
			s_d.dout = wide ? serve_word : {HPP_BYTE_ZERO,
				sel_hi ? serve_word[15:8] : serve_word[7:0]};
		end
		// write: sample while strobed, commit on release
		if (wr_act) begin
			s_d.hold_addr = host_word_addr;
			s_d.hold_lane = lane;
			s_d.hold_data = host_data_bus_i;
		end
		if (wr_act && !s_q.wr_prev) begin
			s_d.cur_valid = 1'b0;
			s_d.pf_valid = 1'b0;
			s_d.pf_req = 1'b0;
			if (s_q.state == HPP_PREF) begin
				s_d.pf_drop = 1'b1;
			end
		end
		if (!wr_act && s_q.wr_prev) begin
			if (wide) begin
				s_d.wr_word = s_q.hold_data;
				s_d.wr_addr = s_q.hold_addr;
				s_d.wr_pend = 1'b1;
			end else begin
				// a word is written only once its second byte lands
				if (hsel_hi) begin
					s_d.wr_word[15:8] = s_q.hold_data[7:0];
				end else begin
					s_d.wr_word[7:0] = s_q.hold_data[7:0];
				end
				if (s_q.hold_lane != HPP_LANE_FIRST) begin
					s_d.wr_addr = s_q.hold_addr;
					s_d.wr_pend = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign host_data_bus_o = s_q.dout;
	assign host_data_oe_lo = rd_act;
	assign host_data_oe_hi = rd_act && wide;
	assign mem_req = s_q.state != HPP_IDLE;
	assign mem_we = s_q.state == HPP_WRITE;
	assign mem_addr = s_q.op_addr;
	assign mem_wdata = s_q.op_wdata;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_miss_stall_on: assert property (
		rd_start && !pf_hit && !reuse |-> host_stall == stall_polarity_select)
		else $error("new read not stalled");
	a_stall_held: assert property (
		rd_act && !rd_start && !cur_ok |-> host_stall == stall_polarity_select)
		else $error("stall level wrong while fetching");
	a_fetch_release: assert property (
		(s_q.state == HPP_FETCH && mem_ack && rd_act) ##1 rd_act
		|-> host_stall != stall_polarity_select && s_q.dout == $past(
		wide ? mem_rdata : s_q.dout) || !wide)
		else $error("stall not released after fetch");
	a_prefetch_next: assert property (
		s_q.state == HPP_FETCH && mem_ack && !wr_act && !rd_start
		|=> s_q.pf_req ##1 s_q.state == HPP_PREF &&
		mem_addr == $past(s_q.cur_addr) + AW'(1) || s_q.wr_pend)
		else $error("no read-ahead after read");
	a_hit_no_stall: assert property (
		rd_start && pf_hit |-> host_stall != stall_polarity_select)
		else $error("read-ahead hit stalled");
	a_write_kills: assert property (
		wr_act && !s_q.wr_prev |=> !s_q.pf_valid && !s_q.cur_valid)
		else $error("write left read-ahead word valid");
	a_cs_ignored: assert property (
		chip_sel_n |-> !host_data_oe_lo && !host_data_oe_hi &&
		host_stall != stall_polarity_select)
		else $error("access while chip select inactive");
	a_narrow_bus: assert property (
		!wide |-> !host_data_oe_hi)
		else $error("upper lines driven in byte mode");
	a_byte_pair: assert property (
		!wide && !wr_act && s_q.wr_prev && s_q.hold_lane == HPP_LANE_FIRST
		&& !s_q.wr_pend |=> !s_q.wr_pend)
		else $error("first byte wrote a word");
	a_common_write: assert property (
		!chip_sel_n && strobe_style_select != HPP_STYLE_SEPARATE &&
		!common_access_pulse_n && dir_or_write_n != HPP_DIR_READ
		|=> s_q.wr_prev)
		else $error("common strobe write missed");
endmodule

// *** test/hpp_host_model.sv ***
// Purpose: host bus master model for the host parallel bus port
// Assumes: pins change just after rising clk edges
// Notes: address moves only while chip select and direction are high
`timescale 1ns/1ns
module hpp_host_model
	import hpp_pkg::*;
(
	input wire logic clk,
	input wire logic host_stall,
	input wire logic stall_polarity_select,
	input wire logic [HPP_DW-1:0] host_data_bus_o,
	output logic chip_sel_n,
	output logic dir_or_write_n,
	output logic common_access_pulse_n,
	output logic [HPP_AW-1:0] host_word_addr,
	output logic byte_lane_addr,
	output logic [HPP_DW-1:0] host_data_bus_i
);
	// --------------------------------
	// one access
	// --------------------------------
	initial begin
		chip_sel_n = 1'b1;
		dir_or_write_n = 1'b1;
		common_access_pulse_n = 1'b1;
		host_word_addr = 14'h0000;
		byte_lane_addr = 1'b0;
		host_data_bus_i = 16'hffff;
	end
	// read pins look alike in both strobe styles
	task automatic acc(input logic we, input logic [HPP_AW-1:0] a,
		input logic ln, input logic [HPP_DW-1:0] wd, input logic cs,
		input logic sty, output logic [HPP_DW-1:0] rd, output logic st);
		int n;
		n = 0;
		st = 1'b0;
		@(posedge clk);
		host_word_addr <= a;
		byte_lane_addr <= ln;
		host_data_bus_i <= we ? wd : ~wd;
		@(posedge clk);
		chip_sel_n <= cs;
		dir_or_write_n <= !we;
		common_access_pulse_n <= we & sty;
		do begin
			@(posedge clk);
			n++;
			if (host_stall === stall_polarity_select)
				st = 1'b1;
		end while (n < 40 && (n < 2 || host_stall === stall_polarity_select));
		rd = host_data_bus_o;
		chip_sel_n <= 1'b1;
		dir_or_write_n <= 1'b1;
		common_access_pulse_n <= 1'b1;
		// no stall on writes, so a fixed gap covers the commit
		repeat (we ? 8 : 0) @(posedge clk);
	endtask
endmodule

// *** test/tb_host_parallel_bus_port.sv ***
// Purpose: self-checking bench for the host parallel bus port
// Assumes: storage answers after lat idle cycles, preset contents
// Notes: storage is modelled here, the host in its own module
`timescale 1ns/1ns
module tb_host_parallel_bus_port
	import hpp_pkg::*;
();
	// --------------------------------
	// signals, storage model
	// --------------------------------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sty = 1'b1, pol = 1'b0, wid = 1'b1, ord = 1'b0;
	logic cs_n, dir, str_n, lane, stall, req, we, st, oe_lo, oe_hi;
	logic ack = 1'b0;
	logic [HPP_AW-1:0] addr, maddr;
	logic [HPP_DW-1:0] di, dout, wdat, got;
	logic [HPP_DW-1:0] rdat = 16'h0000;
	logic [HPP_DW-1:0] mem [0:63];
	int lat = 0, cnt = 0, nreq = 0, n0 = 0, err_count = 0, num_checks = 0;
	always #10 clk = ~clk;
	initial begin
		for (int i = 0; i < 64; i++)
			mem[i] = pat(14'(i));
	end
	always @(posedge req) nreq++;
	always @(posedge clk) begin
		ack <= 1'b0;
		rdat <= ~rdat;
		if (req && !ack && cnt < lat)
			cnt <= cnt + 1;
		else if (req && !ack) begin
			cnt <= 0;
			ack <= 1'b1;
			if (we)
				mem[maddr[5:0]] <= wdat;
			else
				rdat <= mem[maddr[5:0]];
		end
	end
	hpp_port #(.AW(HPP_AW)) dut (.clk(clk), .sys_rst(sys_rst),
		.strobe_style_select(sty), .stall_polarity_select(pol),
		.host_width_select(wid), .byte_order_select(ord),
		.chip_sel_n(cs_n), .dir_or_write_n(dir),
		.common_access_pulse_n(str_n), .host_word_addr(addr),
		.byte_lane_addr(lane), .host_data_bus_i(di),
		.host_data_bus_o(dout), .host_data_oe_lo(oe_lo),
		.host_data_oe_hi(oe_hi),
		.host_stall(stall), .mem_req(req), .mem_we(we), .mem_addr(maddr),
		.mem_wdata(wdat), .mem_ack(ack), .mem_rdata(rdat));
	hpp_host_model host (.clk(clk), .host_stall(stall),
		.stall_polarity_select(pol), .host_data_bus_o(dout),
		.chip_sel_n(cs_n), .dir_or_write_n(dir),
		.common_access_pulse_n(str_n), .host_word_addr(addr),
		.byte_lane_addr(lane), .host_data_bus_i(di));
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [HPP_DW-1:0] pat(input logic [HPP_AW-1:0] a);
		return 16'h5a00 + 16'(a);
	endfunction
	task automatic chk(input logic [HPP_DW-1:0] g, e, input logic s, es);
		num_checks++;
		if (g !== e || s !== es) begin
			err_count++;
			$display("BAD %0t data %h exp %h stall %b exp %b", $time, g, e, s, es);
		end
	endtask
	// looked at on the last strobed edge, before the host lets go
	task automatic chk_oe(input logic el, eh);
		num_checks++;
		if (oe_lo !== el || oe_hi !== eh) begin
			err_count++;
			$display("BAD %0t data enables %b%b", $time, oe_hi, oe_lo);
		end
	endtask
	task automatic rc(input logic [HPP_AW-1:0] a, input logic ln,
		input logic [HPP_DW-1:0] e, input logic es);
		host.acc(1'b0, a, ln, 16'h0000, 1'b0, sty, got, st);
		chk(got, e, st, es);
		chk_oe(1'b1, wid);
	endtask
	task automatic wr(input logic [HPP_AW-1:0] a, input logic ln,
		input logic [HPP_DW-1:0] d, input logic cs);
		host.acc(1'b1, a, ln, d, cs, sty, got, st);
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_seq;
		rc(14'h0004, 1'b0, pat(14'h0004), 1'b1);
		rc(14'h0005, 1'b0, pat(14'h0005), 1'b0);
		repeat (20) @(posedge clk);
		rc(14'h0006, 1'b0, pat(14'h0006), 1'b0);
		rc(14'h0009, 1'b0, pat(14'h0009), 1'b1);
		$display("test seq done");
	endtask
	task automatic t_write;
		rc(14'h000a, 1'b0, pat(14'h000a), 1'b1);
		wr(14'h000b, 1'b0, 16'h1234, 1'b0);
		rc(14'h000b, 1'b0, 16'h1234, 1'b1);
		repeat (8) @(posedge clk);
		rc(14'h000c, 1'b0, pat(14'h000c), 1'b0);
		$display("test write done");
	endtask
	task automatic t_cs;
		rc(14'h0014, 1'b0, pat(14'h0014), 1'b1);
		repeat (4) @(posedge clk);
		n0 = nreq;
		wr(14'h0015, 1'b0, 16'hdead, 1'b1);
		host.acc(1'b0, 14'h001e, 1'b0, 16'h0000, 1'b1, sty, got, st);
		chk_oe(1'b0, 1'b0);
		chk(16'(nreq - n0), 16'h0000, st, 1'b0);
		rc(14'h0015, 1'b0, pat(14'h0015), 1'b0);
		$display("test chip select done");
	endtask
	task automatic t_byte;
		rc(14'h001e, 1'b0, 16'h005a, 1'b1);
		rc(14'h001e, 1'b1, 16'h001e, 1'b0);
		ord <= 1'b0;
		rc(14'h0028, 1'b0, 16'h0028, 1'b1);
		rc(14'h0028, 1'b1, 16'h005a, 1'b0);
		wr(14'h0029, 1'b0, 16'h0034, 1'b0);
		wr(14'h0029, 1'b1, 16'h0012, 1'b0);
		wid <= 1'b1;
		rc(14'h0029, 1'b0, 16'h1234, 1'b1);
		$display("test byte done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// --------------------------------
	// main sequence, watchdog
	// --------------------------------
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_seq();
		sty <= 1'b0;
		pol <= 1'b1;
		lat <= 3;
		t_write();
		sty <= 1'b1;
		pol <= 1'b0;
		lat <= 0;
		t_cs();
		wid <= 1'b0;
		ord <= 1'b1;
		lat <= 1;
		t_byte();
		finish_test();
	end
	// the tests need well under a thousand cycles
	initial begin
		#100000;
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		finish_test();
	end
endmodule
